//--- core/sprf_defines.svh
`ifndef SPRF_DEFINES_SVH
`define SPRF_DEFINES_SVH

// Register byte offsets
`define SPRF_OFS_CTRL 8'h00
`define SPRF_OFS_STATUS 8'h04
`define SPRF_OFS_MASK 8'h08
`define SPRF_OFS_RESULT 8'h0c

// Control fields
`define SPRF_CTRL_PARITY_BIT 0
`define SPRF_CTRL_RESET 32'h0000_0000

// Status and mask fields
`define SPRF_EV_DONE 0
`define SPRF_EV_CRC 1
`define SPRF_EV_COLL 2
`define SPRF_EV_OVF 3
`define SPRF_EV_WIDTH 4
`define SPRF_EV_RESET 4'h0

// Response codes and bytes
`define SPRF_CODE_OK 8'h80
`define SPRF_CODE_PARTIAL 8'h90
`define SPRF_PAR_ONE 8'h80
`define SPRF_PAR_ZERO 8'h00

// Status byte fields
`define SPRF_STB_CRC 1
`define SPRF_STB_COLL 0

// Receive store
`define SPRF_DEPTH 128
`define SPRF_IDX_W 7
`define SPRF_CNT_W 8

`endif

//--- core/sprf_pkg.sv
package sprf_pkg;

    typedef struct packed {
        logic [7:0] data;
        logic parity;
    } sprf_rxbyte_t;

    typedef struct packed {
        logic crcErr;
        logic collision;
        logic partial;
    } sprf_rxend_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } sprf_bus_t;

    typedef enum logic [2:0] {
        SPRF_IDLE = 3'b000,
        SPRF_CODE = 3'b001,
        SPRF_LEN = 3'b010,
        SPRF_DATA = 3'b011,
        SPRF_PAR = 3'b100,
        SPRF_STAT = 3'b101
    } sprf_state_t;

endpackage

//--- core/sprf_framer.sv
// The address-and-strobe port and the address map are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
`include "sprf_defines.svh"

module sprf_framer
    import sprf_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic ce,
    input wire sprf_bus_t bus,
    output logic [31:0] rdData,
    input wire logic rxValid,
    input wire sprf_rxbyte_t rxByte,
    input wire logic rxEnd,
    input wire sprf_rxend_t rxEndInfo,
    output logic rxBusy,
    output logic respValid,
    output logic [7:0] respData,
    output logic respLast,
    input wire logic respReady,
    output logic irq
);

    sprf_state_t state;
    sprf_rxbyte_t mem [`SPRF_DEPTH];
    logic [`SPRF_CNT_W-1:0] cnt;
    logic [`SPRF_IDX_W-1:0] idx;
    logic parityMode;
    logic modeLat;
    logic crcLat;
    logic collLat;
    logic [7:0] codeLat;
    logic [`SPRF_EV_WIDTH-1:0] status;
    logic [`SPRF_EV_WIDTH-1:0] mask;
    logic [`SPRF_EV_WIDTH-1:0] evSet;
    logic take;
    logic accept;
    logic full;
    logic lastIdx;
    logic [7:0] lenByte;
    logic [7:0] statByte;

    function automatic logic [7:0] length_of(input logic [`SPRF_CNT_W-1:0] n, input logic par);
        logic [8:0] w;
        w = par ? {n, 1'b0} : {1'b0, n};
        length_of = w[7:0] + 8'h01;
    endfunction

    assign take = ce && respValid && respReady;
    assign full = (cnt == `SPRF_CNT_W'(`SPRF_DEPTH)) || (parityMode && cnt == `SPRF_CNT_W'(`SPRF_DEPTH - 1));
    assign accept = ce && (state == SPRF_IDLE) && rxValid && !full;
    assign lastIdx = ({1'b0, idx} + 8'h01) == cnt;
    assign lenByte = length_of(cnt, modeLat);
    assign statByte = {6'h00, crcLat, collLat};
    assign respValid = (state != SPRF_IDLE);
    assign respLast = (state == SPRF_STAT);
    assign rxBusy = (state != SPRF_IDLE);

    // Receive store, bytes kept exactly as received
    always_ff @(posedge clk) begin
        if (reset) begin
            cnt <= '0;
        end else if (ce) begin
            if (accept) begin
                mem[cnt[`SPRF_IDX_W-1:0]] <= rxByte;
                cnt <= cnt + 8'h01;
            end else if (state == SPRF_STAT && take) begin
                cnt <= '0;
            end
        end
    end

    // End-of-frame capture
    always_ff @(posedge clk) begin
        if (reset) begin
            modeLat <= 1'b0;
            crcLat <= 1'b0;
            collLat <= 1'b0;
            codeLat <= `SPRF_CODE_OK;
        end else if (ce && state == SPRF_IDLE && rxEnd) begin
            modeLat <= parityMode;
            crcLat <= rxEndInfo.crcErr;
            collLat <= rxEndInfo.collision;
            codeLat <= rxEndInfo.partial ? `SPRF_CODE_PARTIAL : `SPRF_CODE_OK;
        end
    end

    // Response sequencer
    always_ff @(posedge clk) begin
        if (reset) begin
            state <= SPRF_IDLE;
            idx <= '0;
            respData <= 8'h00;
        end else if (ce) begin
            unique case (state)
                SPRF_IDLE: begin
                    if (rxEnd) begin
                        state <= SPRF_CODE;
                        respData <= rxEndInfo.partial ? `SPRF_CODE_PARTIAL : `SPRF_CODE_OK;
                    end
                end
                SPRF_CODE: begin
                    if (take) begin
                        state <= SPRF_LEN;
                        respData <= lenByte;
                    end
                end
                SPRF_LEN: begin
                    if (take) begin
                        idx <= '0;
                        if (cnt == '0) begin
                            state <= SPRF_STAT;
                            respData <= statByte;
                        end else begin
                            state <= SPRF_DATA;
                            respData <= mem[0].data;
                        end
                    end
                end
                SPRF_DATA, SPRF_PAR: begin
                    if (take) begin
                        if (state == SPRF_DATA && modeLat) begin
                            state <= SPRF_PAR;
                            respData <= mem[idx].parity ? `SPRF_PAR_ONE : `SPRF_PAR_ZERO;
                        end else if (lastIdx) begin
                            state <= SPRF_STAT;
                            respData <= statByte;
                        end else begin
                            state <= SPRF_DATA;
                            idx <= idx + 7'h01;
                            respData <= mem[idx + 7'h01].data;
                        end
                    end
                end
                SPRF_STAT: begin
                    if (take) begin
                        state <= SPRF_IDLE;
                        respData <= 8'h00;
                    end
                end
                default: begin
                    state <= SPRF_IDLE;
                end
            endcase
        end
    end

    // Event sources
    always_comb begin
        evSet = '0;
        evSet[`SPRF_EV_DONE] = ce && state == SPRF_IDLE && rxEnd;
        evSet[`SPRF_EV_CRC] = ce && state == SPRF_IDLE && rxEnd && rxEndInfo.crcErr;
        evSet[`SPRF_EV_COLL] = ce && state == SPRF_IDLE && rxEnd && rxEndInfo.collision;
        evSet[`SPRF_EV_OVF] = ce && state == SPRF_IDLE && rxValid && full;
    end

    // Control register
    always_ff @(posedge clk) begin
        if (reset) begin
            parityMode <= 1'(`SPRF_CTRL_RESET);
        end else if (ce && bus.wr && bus.addr == `SPRF_OFS_CTRL) begin
            parityMode <= bus.wdata[`SPRF_CTRL_PARITY_BIT];
        end
    end

    // Sticky status, set wins over write-one-to-clear
    always_ff @(posedge clk) begin
        if (reset) begin
            status <= `SPRF_EV_RESET;
        end else if (ce) begin
            if (bus.wr && bus.addr == `SPRF_OFS_STATUS) begin
                status <= (status & ~bus.wdata[`SPRF_EV_WIDTH-1:0]) | evSet;
            end else begin
                status <= status | evSet;
            end
        end
    end

    // Interrupt mask
    always_ff @(posedge clk) begin
        if (reset) begin
            mask <= `SPRF_EV_RESET;
        end else if (ce && bus.wr && bus.addr == `SPRF_OFS_MASK) begin
            mask <= bus.wdata[`SPRF_EV_WIDTH-1:0];
        end
    end

    assign irq = |(status & mask);

    // Read port, data one cycle after the strobe
    always_ff @(posedge clk) begin
        if (reset) begin
            rdData <= 32'h0000_0000;
        end else if (ce) begin
            rdData <= 32'h0000_0000;
            if (bus.rd) begin
                unique case (bus.addr)
                    `SPRF_OFS_CTRL: rdData <= {31'h0000_0000, parityMode};
                    `SPRF_OFS_STATUS: rdData <= {28'h000_0000, status};
                    `SPRF_OFS_MASK: rdData <= {28'h000_0000, mask};
                    `SPRF_OFS_RESULT: rdData <= {12'h000, rxBusy, modeLat, cnt, codeLat, statByte[1:0]};
                    default: rdData <= 32'h0000_0000;
                endcase
            end
        end
    end

    sequence s_frameEnd(logic part);
        ce && state == SPRF_IDLE && rxEnd && rxEndInfo.partial == part;
    endsequence

    sequence s_dataTakenPar;
        take && state == SPRF_DATA && modeLat;
    endsequence

    property p_codeOk;
        @(posedge clk) disable iff (reset)
        s_frameEnd(1'b0) |=> state == SPRF_CODE && respData == 8'h80;
    endproperty
    a_codeOk: assert property (p_codeOk) else $error("Good reply code not 0x80");

    property p_codePartial;
        @(posedge clk) disable iff (reset)
        s_frameEnd(1'b1) |=> state == SPRF_CODE && respData == 8'h90;
    endproperty
    a_codePartial: assert property (p_codePartial) else $error("Partial reply code not 0x90");

    property p_length;
        @(posedge clk) disable iff (reset)
        take && state == SPRF_CODE |=> state == SPRF_LEN && respData == (modeLat ? cnt + cnt + 8'h01 : cnt + 8'h01);
    endproperty
    a_length: assert property (p_length) else $error("Length byte wrong");

    property p_parityFollows;
        @(posedge clk) disable iff (reset)
        s_dataTakenPar |=> state == SPRF_PAR ##1 ($past(take) || state == SPRF_PAR);
    endproperty
    a_parityFollows: assert property (p_parityFollows) else $error("Parity byte not after data");

    property p_parityValue;
        @(posedge clk) disable iff (reset)
        state == SPRF_PAR |-> respData == (mem[idx].parity ? 8'h80 : 8'h00);
    endproperty
    a_parityValue: assert property (p_parityValue) else $error("Parity byte encoding wrong");

    property p_storeRaw;
        @(posedge clk) disable iff (reset)
        accept |=> mem[$past(cnt[`SPRF_IDX_W-1:0])] == $past(rxByte);
    endproperty
    a_storeRaw: assert property (p_storeRaw) else $error("Received byte altered in store");

    property p_dataRaw;
        @(posedge clk) disable iff (reset)
        state == SPRF_DATA |-> respData == mem[idx].data;
    endproperty
    a_dataRaw: assert property (p_dataRaw) else $error("Data byte not as received");

    property p_statusByte;
        @(posedge clk) disable iff (reset)
        state == SPRF_STAT |-> respData[7:2] == 6'h00 && respData[1] == crcLat && respData[0] == collLat && respLast;
    endproperty
    a_statusByte: assert property (p_statusByte) else $error("Status byte wrong");

    property p_plainNoParity;
        @(posedge clk) disable iff (reset)
        take && state == SPRF_DATA && !modeLat && !lastIdx |=> state == SPRF_DATA;
    endproperty
    a_plainNoParity: assert property (p_plainNoParity) else $error("Parity byte in plain mode");

endmodule

`default_nettype wire

//--- test/sprf_host_model.sv
`timescale 1ns/10ps
`default_nettype none
module sprf_host_model (
    input wire logic clk,
    input wire logic reset,
    input wire logic ce,
    input wire logic clear,
    input wire logic slow,
    input wire logic respValid,
    input wire logic [7:0] respData,
    input wire logic respLast,
    output logic respReady
);
    logic [7:0] got[$];
    logic sawLast;
    // Collects reply bytes, stalling at random when slow
    always @(posedge clk) begin
        if (reset) begin
            respReady <= 1'b0;
            sawLast <= 1'b0;
        end else if (clear) begin
            got.delete();
            sawLast <= 1'b0;
        end else begin
            respReady <= slow ? 1'($urandom) : 1'b1;
            if (ce && respValid && respReady) begin
                got.push_back(respData);
                if (respLast) begin
                    sawLast <= 1'b1;
                end
            end
        end
    end
endmodule
`default_nettype wire

//--- test/test_send_receive_command_parity_framing.sv
`timescale 1ns/10ps
`default_nettype none
`include "sprf_defines.svh"
module test_send_receive_command_parity_framing;
    import sprf_pkg::*;
    logic clk, reset, ce, rxValid, rxEnd, slow, par, clear;
    logic rxBusy, respValid, respLast, respReady, irq;
    logic [7:0] respData;
    logic [31:0] rdData;
    sprf_bus_t bus;
    sprf_rxbyte_t rxByte;
    sprf_rxend_t rxEndInfo;
    int err_count, checked, cycles;
    logic [7:0] exp[$];
    sprf_framer sprf_framer_i (.clk(clk), .reset(reset), .ce(ce), .bus(bus), .rdData(rdData),
        .rxValid(rxValid), .rxByte(rxByte), .rxEnd(rxEnd), .rxEndInfo(rxEndInfo), .rxBusy(rxBusy),
        .respValid(respValid), .respData(respData), .respLast(respLast), .respReady(respReady), .irq(irq));
    sprf_host_model sprf_host_model_i (.clk(clk), .reset(reset), .ce(ce), .clear(clear), .slow(slow),
        .respValid(respValid),
        .respData(respData), .respLast(respLast), .respReady(respReady));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task wrap_up;
        $display("errors %0d checks %0d", err_count, checked);
        if (err_count == 0 && checked > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task chk(input logic [31:0] g, input logic [31:0] e);
        checked++;
        if (g !== e) begin
            err_count++;
            $display("[ERR] %0t got %h expected %h", $time, g, e);
        end
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        bus <= '{a, d, 1'b1, 1'b0};
        @(posedge clk);
        bus.wr <= 1'b0;
    endtask
    task rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        @(posedge clk);
        bus <= '{a, 32'h0, 1'b0, 1'b1};
        @(posedge clk);
        bus.rd <= 1'b0;
        #1 chk(rdData & m, e);
    endtask
    task irqchk(input logic e);
        #1 chk({31'h0, irq}, {31'h0, e});
    endtask
    task frame(input int n, input sprf_rxend_t ei);
        int k;
        int m;
        logic [8:0] b;
        m = (n > (par ? `SPRF_DEPTH - 1 : `SPRF_DEPTH)) ? (par ? `SPRF_DEPTH - 1 : `SPRF_DEPTH) : n;
        exp = {ei.partial ? `SPRF_CODE_PARTIAL : `SPRF_CODE_OK, 8'(par ? 2 * m + 1 : m + 1)};
        @(posedge clk);
        clear <= 1'b1;
        @(posedge clk);
        clear <= 1'b0;
        for (k = 0; k < n; k++) begin
            b = (n == 2) ? (k ? 9'h068 : 9'h065) : 9'($urandom);
            @(posedge clk);
            rxValid <= 1'b1;
            rxByte <= b;
            if (k < m) begin
                exp.push_back(b[8:1]);
                if (par) exp.push_back(b[0] ? `SPRF_PAR_ONE : `SPRF_PAR_ZERO);
            end
        end
        exp.push_back({6'h0, ei.crcErr, ei.collision});
        @(posedge clk);
        rxValid <= 1'b0;
        rxEnd <= 1'b1;
        rxEndInfo <= ei;
        @(posedge clk);
        rxEnd <= 1'b0;
        #1 chk({31'h0, rxBusy}, 32'h1);
        for (k = 0; k < 400 && !sprf_host_model_i.sawLast; k++) begin
            ce <= slow ? 1'($urandom) : 1'b1;
            @(posedge clk);
        end
        ce <= 1'b1;
        @(posedge clk);
        #1 chk({31'h0, rxBusy}, 32'h0);
        chk({31'h0, sprf_host_model_i.sawLast}, 32'h1);
        chk(32'(sprf_host_model_i.got.size()), 32'(exp.size()));
        foreach (exp[i]) chk({24'h0, sprf_host_model_i.got[i]}, {24'h0, exp[i]});
    endtask
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            err_count++;
            wrap_up;
        end
    end
    initial begin
        reset = 1'b1;
        ce = 1'b1;
        bus = '0;
        rxValid = 1'b0;
        rxByte = '0;
        rxEnd = 1'b0;
        rxEndInfo = '0;
        slow = 1'b0;
        clear = 1'b0;
        par = 1'b1;
        void'($urandom(77));
        repeat (12) @(posedge clk);
        reset <= 1'b0;
        rd(`SPRF_OFS_CTRL, 32'hffffffff, 32'h0);
        rd(`SPRF_OFS_MASK, 32'hffffffff, 32'h0);
        rd(8'hf0, 32'hffffffff, 32'h0);
        ce <= 1'b0;
        wr(`SPRF_OFS_CTRL, 32'h1);
        ce <= 1'b1;
        rd(`SPRF_OFS_CTRL, 32'hffffffff, 32'h0);
        wr(`SPRF_OFS_CTRL, 32'h1);
        frame(2, 3'b000);
        rd(`SPRF_OFS_RESULT, 32'h0004_03ff, 32'h0004_0200);
        rd(`SPRF_OFS_STATUS, 32'hf, 32'h1);
        irqchk(1'b0);
        wr(`SPRF_OFS_MASK, 32'hf);
        irqchk(1'b1);
        wr(`SPRF_OFS_STATUS, 32'hf);
        irqchk(1'b0);
        wr(`SPRF_OFS_CTRL, 32'h0);
        par = 1'b0;
        frame(0, 3'b110);
        rd(`SPRF_OFS_STATUS, 32'hf, 32'h7);
        irqchk(1'b1);
        wr(`SPRF_OFS_STATUS, 32'hf);
        frame(1, 3'b001);
        frame(129, 3'b000);
        rd(`SPRF_OFS_STATUS, 32'hf, 32'h9);
        repeat (10) begin
            par = 1'($urandom);
            wr(`SPRF_OFS_CTRL, {31'h0, par});
            slow <= 1'($urandom);
            frame($urandom % 13, 3'($urandom));
        end
        wrap_up;
    end
endmodule
`default_nettype wire
